/* src/srs_pkg.sv */
package srs_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [3:0] SRS_ADDR_SWCTL    = 4'h0;
	localparam logic [3:0] SRS_ADDR_INT_BCTL = 4'h1;
	localparam logic [3:0] SRS_ADDR_EXT_BCTL = 4'h2;
	localparam logic [3:0] SRS_ADDR_GPIO_FN  = 4'h3;
	localparam logic [3:0] SRS_ADDR_GPIO_DIR = 4'h4;
	localparam logic [3:0] SRS_ADDR_GPIO_OUT = 4'h5;
	localparam logic [3:0] SRS_ADDR_STATUS   = 4'h6;
	localparam logic [3:0] SRS_ADDR_STICKY   = 4'h7;
	localparam logic [3:0] SRS_ADDR_CFGLOAD  = 4'h8;
	localparam logic [3:0] SRS_ADDR_VOLATILE = 4'h9;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int SRS_BIT_RESET     = 0;
	localparam int SRS_BIT_PROPAGATE = 1;
	localparam int SRS_BIT_NT_MODE   = 4;
	localparam int SRS_BIT_CFG_DONE  = 0;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [31:0] SRS_RST_ZERO   = 32'h0000_0000;
	localparam logic [7:0]  SRS_RST_GPIO   = 8'h00;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int SRS_CLK_PERIOD_PS    = 5000;
	localparam int SRS_PULSE_MIN_NS     = 250;
	localparam int SRS_PULSE_CYCLES     = (SRS_PULSE_MIN_NS * 1000 + SRS_CLK_PERIOD_PS - 1) / SRS_CLK_PERIOD_PS;
	localparam int SRS_NORMAL_OP_MS     = 1000;
	localparam int SRS_CFG_LOAD_MS      = 200;
	localparam int SRS_CFG_LOAD_CYCLES  = SRS_CFG_LOAD_MS * 1000 * 200;
	localparam int SRS_FUND_HOLD_CYCLES = 4;

	// ****************************************************************
	// Sequencer states
	// ****************************************************************
	typedef enum logic [3:0] {
		SRS_ST_RUN     = 4'b0001,
		SRS_ST_FUND    = 4'b0010,
		SRS_ST_HOT_MSG = 4'b0100,
		SRS_ST_HOT_RST = 4'b1000
	} srs_state_t;

endpackage : srs_pkg

/* src/srs_pulse.sv */
`timescale 1ns/1ps
module srs_pulse
	import srs_pkg::*;
#(
	parameter int CYCLES = SRS_PULSE_CYCLES
) (
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic start,
	output logic      active
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	logic [CW-1:0] count;

	// Active (high) period held for at least CYCLES edges; a retrigger restarts it
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			active <= 1'b0;
			count  <= '0;
		end else if (start) begin
			active <= 1'b1;
			count  <= '0;
		end else if (active) begin
			if (count == LAST) begin
				active <= 1'b0;
			end else begin
				count <= count + CW'(1);
			end
		end
	end
endmodule : srs_pulse

/* src/srs_top.sv */
`timescale 1ns/1ps
module srs_top
	import srs_pkg::*;
#(
	parameter int GPIO_W     = 8,
	parameter int LOAD_LIMIT = SRS_CFG_LOAD_CYCLES
) (
	input  wire logic              mclk,
	input  wire logic              rst_n,
	input  wire logic [3:0]        addr,
	input  wire logic [31:0]       wdata,
	input  wire logic              wr,
	input  wire logic              rd,
	output logic      [31:0]       rdata,
	input  wire logic              board_reset_n,
	input  wire logic              bridge_side_reset_n,
	input  wire logic              up_ts1_hot_reset,
	input  wire logic              up_dl_down,
	input  wire logic [1:0]        dn_ts1_hot_reset,
	input  wire logic              ext_hot_reset,
	input  wire logic [1:0]        dn_hot_msg_done,
	input  wire logic [GPIO_W-1:0] gpio_in,
	output logic      [GPIO_W-1:0] gpio_out,
	output logic      [GPIO_W-1:0] gpio_oe,
	output logic                   fund_reset,
	output logic                   core_hot_reset,
	output logic      [1:0]        dn_hot_msg_req,
	output logic      [1:0]        dn_port_reset,
	output logic                   cfg_load_req,
	output logic                   cfg_load_late
);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [6:0]        sync_a;
	logic [6:0]        sync_b;
	logic [GPIO_W-1:0] gpio_a;
	logic [GPIO_W-1:0] gpio_s;
	logic              board_n_s;
	logic              bridge_n_s;
	logic              ts1_s;
	logic              dl_s;
	logic              ext_s;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			sync_a <= 7'h7f;
			sync_b <= 7'h7f;
			gpio_a <= '0;
			gpio_s <= '0;
		end else begin
			sync_a <= {board_reset_n, bridge_side_reset_n, ~up_ts1_hot_reset, ~up_dl_down, ~ext_hot_reset,
				~dn_ts1_hot_reset};
			sync_b <= sync_a;
			gpio_a <= gpio_in;
			gpio_s <= gpio_a;
		end
	end
	assign board_n_s  = sync_b[6];
	assign bridge_n_s = sync_b[5];
	assign ts1_s      = ~sync_b[4];
	assign dl_s       = ~sync_b[3];
	assign ext_s      = ~sync_b[2];

	// ****************************************************************
	// Registers
	// ****************************************************************
	logic [31:0]       swctl;
	logic [31:0]       int_bctl;
	logic [31:0]       ext_bctl;
	logic [GPIO_W-1:0] gpio_fn;
	logic [GPIO_W-1:0] gpio_dir;
	logic [GPIO_W-1:0] gpio_val;
	logic [31:0]       sticky;
	logic [31:0]       volatile_reg;
	logic              cfg_done;
	srs_state_t        state;
	logic              nt_mode;
	logic              fund_req;
	logic              hot_req;
	logic              hot_clear;
	logic              fund_clear;
	logic [1:0]        local_req;

	function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] target, input logic w);
		wr_hit = w && (a == target);
	endfunction : wr_hit

	assign nt_mode = swctl[SRS_BIT_NT_MODE];

	// In NT mode, internal- and external-side reset bits and bridge input (gated by propagate) start a fundamental reset
	assign fund_req = !board_n_s
		|| (wr_hit(addr, SRS_ADDR_SWCTL, wr) && wdata[SRS_BIT_RESET])
		|| (nt_mode && wr_hit(addr, SRS_ADDR_EXT_BCTL, wr) && wdata[SRS_BIT_RESET])
		|| (nt_mode && wr_hit(addr, SRS_ADDR_INT_BCTL, wr) && wdata[SRS_BIT_RESET])
		|| (nt_mode && !bridge_n_s && (int_bctl[SRS_BIT_PROPAGATE] || ext_bctl[SRS_BIT_PROPAGATE]));

	// Upstream triggers, plus the external hot reset in NT mode; downstream hot-reset ordered sets are not looked at
	assign hot_req = ts1_s || dl_s
		|| (nt_mode && ext_s);

	// Per-port local hot reset through volatile register bits
	assign local_req = wr_hit(addr, SRS_ADDR_VOLATILE, wr) ? wdata[9:8] : 2'b00;

	assign fund_clear = (state == SRS_ST_FUND);
	assign hot_clear  = (state == SRS_ST_HOT_RST) || fund_clear;

	// Sticky fields: cleared only by fundamental reset
	always_ff @(posedge mclk) begin
		if (!rst_n || fund_clear) begin
			sticky <= SRS_RST_ZERO;
		end else if (wr_hit(addr, SRS_ADDR_STICKY, wr)) begin
			sticky <= wdata;
		end
	end

	// Control registers: fundamental clears all, hot reset clears volatile parts only
	always_ff @(posedge mclk) begin
		if (!rst_n || fund_clear) begin
			swctl    <= SRS_RST_ZERO;
			int_bctl <= SRS_RST_ZERO;
			ext_bctl <= SRS_RST_ZERO;
		end else if (hot_clear) begin
			swctl    <= swctl & 32'h0000_0010;
			int_bctl <= int_bctl & 32'h0000_0002;
			ext_bctl <= ext_bctl & 32'h0000_0002;
		end else begin
			if (wr_hit(addr, SRS_ADDR_SWCTL, wr)) begin
				swctl <= wdata & 32'hffff_fffe;
			end
			if (wr_hit(addr, SRS_ADDR_INT_BCTL, wr)) begin
				int_bctl <= wdata & 32'hffff_fffe;
			end
			if (wr_hit(addr, SRS_ADDR_EXT_BCTL, wr)) begin
				ext_bctl <= wdata & 32'hffff_fffe;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n || hot_clear) begin
			volatile_reg <= SRS_RST_ZERO;
		end else if (wr_hit(addr, SRS_ADDR_VOLATILE, wr)) begin
			volatile_reg <= wdata & 32'hffff_fcff;
		end
	end

	// GPIO: fundamental and global hot resets return pins to inputs, releasing the reset outputs
	always_ff @(posedge mclk) begin
		if (!rst_n || hot_clear || state == SRS_ST_HOT_MSG) begin
			gpio_fn  <= SRS_RST_GPIO;
			gpio_dir <= SRS_RST_GPIO;
			gpio_val <= SRS_RST_GPIO;
		end else begin
			if (wr_hit(addr, SRS_ADDR_GPIO_FN, wr)) begin
				gpio_fn <= wdata[GPIO_W-1:0];
			end
			if (wr_hit(addr, SRS_ADDR_GPIO_DIR, wr)) begin
				gpio_dir <= wdata[GPIO_W-1:0];
			end
			if (wr_hit(addr, SRS_ADDR_GPIO_OUT, wr)) begin
				gpio_val <= wdata[GPIO_W-1:0];
			end
		end
	end

	// ****************************************************************
	// Configuration load window
	// ****************************************************************
	logic [31:0] load_cnt;

	// Load runs only after fundamental reset, never after hot reset
	always_ff @(posedge mclk) begin
		if (!rst_n || fund_clear) begin
			cfg_done      <= 1'b0;
			load_cnt      <= '0;
			cfg_load_req  <= 1'b1;
			cfg_load_late <= 1'b0;
		end else if (!cfg_done) begin
			if (wr_hit(addr, SRS_ADDR_CFGLOAD, wr) && wdata[SRS_BIT_CFG_DONE]) begin
				cfg_done     <= 1'b1;
				cfg_load_req <= 1'b0;
			end else if (load_cnt == 32'(LOAD_LIMIT - 1)) begin
				cfg_load_late <= 1'b1;
			end else begin
				load_cnt <= load_cnt + 32'h1;
			end
		end
	end

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	logic [SRS_FUND_HOLD_CYCLES-1:0] hold;
	logic [1:0]                      msg_seen;
	logic                            global_hot;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state      <= SRS_ST_FUND;
			hold       <= '0;
			msg_seen   <= 2'b00;
			global_hot <= 1'b0;
		end else if (fund_req) begin
			state <= SRS_ST_FUND;
			hold  <= '0;
		end else begin
			case (state)
				SRS_ST_RUN: begin
					if (hot_req) begin
						state      <= SRS_ST_HOT_MSG;
						msg_seen   <= 2'b00;
						global_hot <= 1'b1;
					end
				end
				SRS_ST_FUND: begin
					hold <= {hold[SRS_FUND_HOLD_CYCLES-2:0], 1'b1};
					if (hold[SRS_FUND_HOLD_CYCLES-1]) begin
						state <= SRS_ST_RUN;
					end
				end
				SRS_ST_HOT_MSG: begin
					msg_seen <= msg_seen | dn_hot_msg_done;
					if (&(msg_seen | dn_hot_msg_done)) begin
						state <= SRS_ST_HOT_RST;
					end
				end
				SRS_ST_HOT_RST: begin
					if (!hot_req) begin
						state      <= SRS_ST_RUN;
						global_hot <= 1'b0;
					end
				end
				default: begin
					state <= SRS_ST_FUND;
				end
			endcase
		end
	end

	// ****************************************************************
	// Downstream reset pulses and outputs
	// ****************************************************************
	logic [1:0] pulse_on;
	logic [1:0] pulse_start;
	assign pulse_start = {2{state == SRS_ST_HOT_MSG && &(msg_seen | dn_hot_msg_done)}} | local_req;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_port
			srs_pulse #(
				.CYCLES (SRS_PULSE_CYCLES)
			) u_pulse (
				.mclk   (mclk),
				.rst_n  (rst_n),
				.start  (pulse_start[gi]),
				.active (pulse_on[gi])
			);
		end
	endgenerate

	// Port B reset on pin 0, port C on pin 1, when alternate function selected
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			gpio_out <= '0;
			gpio_oe  <= '0;
		end else begin
			gpio_out <= gpio_val;
			gpio_oe  <= gpio_dir & ~gpio_fn;
			if (gpio_fn[0]) begin
				gpio_out[0] <= ~pulse_on[0];
				gpio_oe[0]  <= 1'b1;
			end
			if (gpio_fn[1]) begin
				gpio_out[1] <= ~pulse_on[1];
				gpio_oe[1]  <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			fund_reset     <= 1'b1;
			core_hot_reset <= 1'b0;
			dn_hot_msg_req <= 2'b00;
			dn_port_reset  <= 2'b00;
		end else begin
			fund_reset     <= (state == SRS_ST_FUND);
			core_hot_reset <= (state == SRS_ST_HOT_RST) && global_hot;
			dn_hot_msg_req <= {2{state == SRS_ST_HOT_MSG}} & ~msg_seen;
			dn_port_reset  <= pulse_on;
		end
	end

	// ****************************************************************
	// Read port
	// ****************************************************************
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rdata <= '0;
		end else if (rd) begin
			case (addr)
				SRS_ADDR_SWCTL:    rdata <= swctl;
				SRS_ADDR_INT_BCTL: rdata <= int_bctl;
				SRS_ADDR_EXT_BCTL: rdata <= ext_bctl;
				SRS_ADDR_GPIO_FN:  rdata <= 32'(gpio_fn);
				SRS_ADDR_GPIO_DIR: rdata <= 32'(gpio_dir);
				SRS_ADDR_GPIO_OUT: rdata <= 32'(gpio_s);
				SRS_ADDR_STATUS:   rdata <= {22'h0, ~sync_b[1:0], pulse_on, state, cfg_load_late, cfg_done};
				SRS_ADDR_STICKY:   rdata <= sticky;
				SRS_ADDR_CFGLOAD:  rdata <= {30'h0, cfg_load_late, cfg_done};
				SRS_ADDR_VOLATILE: rdata <= volatile_reg;
				default:           rdata <= '0;
			endcase
		end else begin
			rdata <= '0;
		end
	end
endmodule : srs_top

/* dv/srs_top_properties.sv */
`timescale 1ns/1ps
module srs_top_properties
	import srs_pkg::*;
#(
	parameter int GPIO_W     = 8,
	parameter int LOAD_LIMIT = SRS_CFG_LOAD_CYCLES
) (
	input logic              mclk,
	input logic              rst_n,
	input logic [3:0]        addr,
	input logic [31:0]       wdata,
	input logic              wr,
	input logic              rd,
	input logic [31:0]       rdata,
	input logic              board_reset_n,
	input logic              bridge_side_reset_n,
	input logic              up_ts1_hot_reset,
	input logic              up_dl_down,
	input logic [1:0]        dn_ts1_hot_reset,
	input logic              ext_hot_reset,
	input logic [1:0]        dn_hot_msg_done,
	input logic [GPIO_W-1:0] gpio_in,
	input logic [GPIO_W-1:0] gpio_out,
	input logic [GPIO_W-1:0] gpio_oe,
	input logic              fund_reset,
	input logic              core_hot_reset,
	input logic [1:0]        dn_hot_msg_req,
	input logic [1:0]        dn_port_reset,
	input logic              cfg_load_req,
	input logic              cfg_load_late
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// ****************************************************************
	// Helper logic
	// ****************************************************************
	logic [5:0] trig_hist;
	logic [7:0] width_b;
	always_ff @(posedge mclk) begin
		if (!rst_n) trig_hist <= 6'h00;
		else trig_hist <= {trig_hist[4:0], up_ts1_hot_reset | up_dl_down | ext_hot_reset};
	end
	always_ff @(posedge mclk) begin
		if (!rst_n || !dn_port_reset[0]) width_b <= 8'h00;
		else if (width_b != 8'hff) width_b <= width_b + 8'h01;
	end
	// ****************************************************************
	// Assertions
	// ****************************************************************
	fund_on_pin_a: assert property ($fell(board_reset_n) |-> ##[1:4] fund_reset)
		else $error("board reset did not start a fundamental reset");
	fund_pins_in_a: assert property (fund_reset && $past(fund_reset) |-> gpio_oe == '0)
		else $error("pin driven during fundamental reset");
	hot_pins_in_a: assert property (core_hot_reset && $past(core_hot_reset) |-> gpio_oe == '0)
		else $error("pin driven during global hot reset");
	msg_first_a: assert property ((dn_port_reset & ~$past(dn_port_reset) & ~$past(dn_hot_msg_done)
		& $past(dn_hot_msg_req)) == 2'b00) else $error("port reset before its message was sent");
	pulse_width_a: assert property ($fell(dn_port_reset[0]) && !fund_reset |-> width_b >= SRS_PULSE_CYCLES)
		else $error("port reset pulse too short");
	down_only_a: assert property ($rose(dn_hot_msg_req[0]) |-> trig_hist != 6'h00)
		else $error("hot reset started without an upstream cause");
	up_trigger_a: assert property (($rose(up_ts1_hot_reset) || $rose(up_dl_down)) && !fund_reset
		&& !core_hot_reset && dn_hot_msg_req == 2'b00 |-> ##[1:6] dn_hot_msg_req == 2'b11)
		else $error("upstream trigger ignored");
	no_reload_a: assert property (core_hot_reset |-> !$rose(cfg_load_req))
		else $error("hot reset restarted the configuration load");
	cover property ($rose(core_hot_reset));
	cover property ($rose(fund_reset));
	cover property ($fell(dn_port_reset[1]));
endmodule : srs_top_properties

bind srs_top srs_top_properties #(.GPIO_W(GPIO_W), .LOAD_LIMIT(LOAD_LIMIT)) i_props (.mclk(mclk), .rst_n(rst_n),
	.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .board_reset_n(board_reset_n),
	.bridge_side_reset_n(bridge_side_reset_n), .up_ts1_hot_reset(up_ts1_hot_reset), .up_dl_down(up_dl_down),
	.dn_ts1_hot_reset(dn_ts1_hot_reset), .ext_hot_reset(ext_hot_reset), .dn_hot_msg_done(dn_hot_msg_done),
	.gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .fund_reset(fund_reset),
	.core_hot_reset(core_hot_reset), .dn_hot_msg_req(dn_hot_msg_req), .dn_port_reset(dn_port_reset),
	.cfg_load_req(cfg_load_req), .cfg_load_late(cfg_load_late));

/* dv/srs_link_partner.sv */
`timescale 1ns/1ps
module srs_link_partner (
	input  logic       mclk,
	input  logic       rst_n,
	input  logic [5:0] delay,
	input  logic [1:0] req,
	output logic [1:0] done
);
	logic [5:0] cnt [2];
	// Port C answers in half the time of port B
	always_ff @(posedge mclk) begin
		for (int i = 0; i < 2; i++) begin
			if (!rst_n || !req[i]) begin
				cnt[i]  <= (i == 0) ? delay : {1'b0, delay[5:1]};
				done[i] <= 1'b0;
			end else if (cnt[i] != 6'h00) begin
				cnt[i] <= cnt[i] - 6'h01;
			end else begin
				done[i] <= 1'b1;
			end
		end
	end
endmodule : srs_link_partner

/* dv/srs_top_tb.sv */
`timescale 1ns/1ps
module srs_top_tb
	import srs_pkg::*;
;
	localparam int LOAD_LIM = 50;
	logic        mclk, rst_n, wr, rd, board_reset_n, bridge_side_reset_n;
	logic        up_ts1_hot_reset, up_dl_down, ext_hot_reset, fund_reset, core_hot_reset;
	logic        cfg_load_req, cfg_load_late;
	logic [3:0]  addr;
	logic [31:0] wdata, rdata, v, s;
	logic [1:0]  dn_ts1_hot_reset, dn_hot_msg_done, dn_hot_msg_req, dn_port_reset;
	logic [7:0]  gpio_in, gpio_out, gpio_oe;
	logic [5:0]  msg_delay;
	int          error_cnt, n_compared, n;
	// Pull-down on every pin
	assign gpio_in = gpio_out & gpio_oe;
	srs_top #(.GPIO_W(8), .LOAD_LIMIT(LOAD_LIM)) i_dut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .board_reset_n(board_reset_n), .bridge_side_reset_n(bridge_side_reset_n),
		.up_ts1_hot_reset(up_ts1_hot_reset), .up_dl_down(up_dl_down), .dn_ts1_hot_reset(dn_ts1_hot_reset),
		.ext_hot_reset(ext_hot_reset), .dn_hot_msg_done(dn_hot_msg_done), .gpio_in(gpio_in), .gpio_out(gpio_out),
		.gpio_oe(gpio_oe), .fund_reset(fund_reset), .core_hot_reset(core_hot_reset), .dn_hot_msg_req(dn_hot_msg_req),
		.dn_port_reset(dn_port_reset), .cfg_load_req(cfg_load_req), .cfg_load_late(cfg_load_late));
	srs_link_partner i_partner (.mclk(mclk), .rst_n(rst_n), .delay(msg_delay), .req(dn_hot_msg_req),
		.done(dn_hot_msg_done));
	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// A fundamental reset wipes sticky fields; otherwise they keep what was written
	function automatic logic [31:0] fund_expect(input bit fired, input logic [31:0] kept);
		fund_expect = fired ? 32'h0 : kept;
	endfunction : fund_expect
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg
	task automatic wait_sig(input string nm, input bit pr, input logic [1:0] val, input int lim);
		n = 0;
		while ((pr ? dn_port_reset : dn_hot_msg_req) !== val && n < lim) begin
			@(posedge mclk);
			#1 n++;
		end
		chk(nm, 32'(n < lim), 32'h1);
	endtask : wait_sig
	task automatic settle();
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while ((fund_reset !== 1'b0 || core_hot_reset !== 1'b0 || dn_port_reset !== 2'b00) && n < 400);
		chk("settle", 32'(n < 400), 32'h1);
	endtask : settle
	task automatic hot_case(input int k);
		s = $urandom;
		v = $urandom & 32'hffff_fcff;
		wr_reg(SRS_ADDR_SWCTL, (k == 2) ? 32'h10 : 32'h0);
		wr_reg(SRS_ADDR_STICKY, s);
		wr_reg(SRS_ADDR_VOLATILE, v);
		wr_reg(SRS_ADDR_GPIO_FN, 32'h3);
		wr_reg(SRS_ADDR_GPIO_DIR, 32'hff);
		@(posedge mclk);
		msg_delay        <= 6'($urandom_range(1, 40));
		up_ts1_hot_reset <= (k == 0);
		up_dl_down       <= (k == 1);
		ext_hot_reset    <= (k == 2);
		wait_sig("msg_req", 0, 2'b11, 10);
		chk("early_rst", 32'(dn_port_reset), 32'h0);
		wait_sig("port_rst", 1, 2'b11, 60);
		chk("hot_oe", 32'(gpio_oe), 32'h0);
		chk("core_hot", 32'(core_hot_reset), 32'h1);
		chk("no_fund", 32'(fund_reset), 32'h0);
		wait_sig("pulse_end", 1, 2'b00, 80);
		chk("pulse_len", 32'(n >= SRS_PULSE_CYCLES), 32'h1);
		@(posedge mclk);
		{up_ts1_hot_reset, up_dl_down, ext_hot_reset} <= 3'b000;
		settle();
		rd_reg(SRS_ADDR_STICKY, v);
		chk("sticky_hot", v, s);
		rd_reg(SRS_ADDR_VOLATILE, v);
		chk("volatile_hot", v, 32'h0);
		rd_reg(SRS_ADDR_GPIO_FN, v);
		chk("fn_hot", v, 32'h0);
		rd_reg(SRS_ADDR_SWCTL, v);
		chk("mode_hot", v & 32'h10, (k == 2) ? 32'h10 : 32'h0);
		chk("no_reload", 32'(cfg_load_req), 32'h0);
	endtask : hot_case
	task automatic fund_case(input int k);
		logic seen;
		seen = 1'b0;
		s = $urandom;
		wr_reg(SRS_ADDR_STICKY, s);
		wr_reg(SRS_ADDR_GPIO_DIR, 32'hff);
		if (k >= 2) wr_reg(SRS_ADDR_SWCTL, 32'h10);
		if (k >= 4) wr_reg((k == 4) ? SRS_ADDR_INT_BCTL : SRS_ADDR_EXT_BCTL, 32'h2);
		if (k == 1) wr_reg(SRS_ADDR_SWCTL, 32'h1);
		if (k == 2) wr_reg(SRS_ADDR_EXT_BCTL, 32'h1);
		for (int i = 0; i < 16; i++) begin
			@(posedge mclk);
			board_reset_n       <= !(k == 0 && i < 4);
			bridge_side_reset_n <= !(k >= 3 && i < 4);
			seen |= fund_reset;
		end
		chk("fund_seen", 32'(seen), 32'(k != 3));
		settle();
		chk("load_req", 32'(cfg_load_req), 32'(k != 3));
		wr_reg(SRS_ADDR_GPIO_DIR, 32'h1);
		@(posedge mclk);
		#1 chk("load_write", 32'(gpio_oe), 32'h1);
		if (k == 0) begin
			repeat (LOAD_LIM + 10) @(posedge mclk);
			chk("load_late", 32'(cfg_load_late), 32'h1);
		end
		wr_reg(SRS_ADDR_CFGLOAD, 32'h1);
		@(posedge mclk);
		chk("load_done", 32'(cfg_load_req), 32'h0);
		if (k != 0) chk("not_late", 32'(cfg_load_late), 32'h0);
		rd_reg(SRS_ADDR_STICKY, v);
		chk("sticky_fund", v, fund_expect(k != 3, s));
	endtask : fund_case
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : report_and_stop
	// ****************************************************************
	// Sequence
	// ****************************************************************
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	initial begin
		#300000;
		error_cnt++;
		report_and_stop();
	end
	initial begin
		{rst_n, wr, rd, up_ts1_hot_reset, up_dl_down, ext_hot_reset} = 6'h00;
		{board_reset_n, bridge_side_reset_n} = 2'b11;
		{addr, wdata, dn_ts1_hot_reset, msg_delay} = '0;
		error_cnt  = 0;
		n_compared = 0;
		void'($urandom(32'h32fc));
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		settle();
		chk("oe_rst", 32'(gpio_oe), 32'h0);
		wr_reg(SRS_ADDR_CFGLOAD, 32'h1);
		s = $urandom;
		wr_reg(SRS_ADDR_STICKY, s);
		rd_reg(SRS_ADDR_STICKY, v);
		chk("sticky_rw", v, s);
		wr_reg(4'hf, $urandom);
		rd_reg(4'hf, v);
		chk("unmapped", v, 32'h0);
		$display("registers done");
		@(posedge mclk);
		dn_ts1_hot_reset <= 2'b11;
		repeat (8) @(posedge mclk);
		chk("dn_ts1", 32'({core_hot_reset, dn_hot_msg_req}), 32'h0);
		rd_reg(SRS_ADDR_STATUS, v);
		chk("dn_ts1_seen", 32'(v[9:8]), 32'h3);
		@(posedge mclk);
		dn_ts1_hot_reset <= 2'b00;
		$display("downstream ordered sets done");
		for (int p = 0; p < 2; p++) begin
			wr_reg(SRS_ADDR_GPIO_FN, 32'h3);
			wr_reg(SRS_ADDR_VOLATILE, 32'h100 << p);
			wait_sig("local", 1, 2'b01 << p, 6);
			chk("pin_low", 32'({gpio_oe[p], gpio_in[p]}), 32'h2);
			wait_sig("local_end", 1, 2'b00, 80);
			chk("local_len", 32'(n >= SRS_PULSE_CYCLES), 32'h1);
		end
		$display("local pulses done");
		for (int k = 0; k < 3; k++) hot_case(k);
		$display("hot resets done");
		for (int k = 0; k < 6; k++) fund_case(k);
		$display("fundamental resets done");
		report_and_stop();
	end
endmodule : srs_top_tb
